// >>> rtl/dtpwm_pkg.sv
// Purpose: shared constants, types and helpers for the dead-time pwm block
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes:   offsets are also used by the checker and the bench; reset values by the top level only
package dtpwm_pkg;

   localparam int unsigned NCH      = 4;
   localparam int unsigned CW       = 16;
   localparam int unsigned DW       = 10;
   localparam int unsigned AW       = 8;
   localparam int unsigned CFG_BITS = 4;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_PERIOD   = 8'h04;
   localparam logic [7:0] OFF_DEADTIME = 8'h08;
   localparam logic [7:0] OFF_OUTCFG   = 8'h0c;
   localparam logic [7:0] OFF_STATUS   = 8'h10;
   localparam logic [7:0] OFF_OUTSTAT  = 8'h14;
   localparam logic [7:0] OFF_MATCH    = 8'h18;
   localparam logic [7:0] OFF_PCOUNT   = 8'h1c;
   localparam logic [7:0] OFF_CMP0     = 8'h20;
   localparam logic [7:0] OFF_CMP_LAST = 8'h2c;

   // control bit positions
   localparam int unsigned CTRL_RUN_BIT    = 0;
   localparam int unsigned CTRL_CENTER_BIT = 1;
   localparam int unsigned CTRL_LOAD_BIT   = 2;

   // per-channel output configuration field, channel x at bits 4x+3..4x
   localparam int unsigned CFG_P_AFTER = 0;
   localparam int unsigned CFG_P_LEVEL = 1;
   localparam int unsigned CFG_C_AFTER = 2;
   localparam int unsigned CFG_C_LEVEL = 3;

   // values after reset
   localparam logic [1:0]  CTRL_RST   = 2'h0;
   localparam logic [15:0] PERIOD_RST = 16'h00ff;
   localparam logic [15:0] CMP_RST    = 16'h0000;
   localparam logic [9:0]  DT_RST     = 10'h000;
   localparam logic [15:0] OUTCFG_RST = 16'h0000;

   typedef enum logic [1:0] {
      DTPWM_IDLE = 2'b00,
      DTPWM_UP   = 2'b01,
      DTPWM_DOWN = 2'b10
   } dtpwm_state_type;

   // output is active on the side of the compare match that is not passive
   function automatic logic dtpwm_active(input logic st, input logic passive_after);
      return passive_after ? ~st : st;
   endfunction

   function automatic logic dtpwm_pin(input logic active, input logic passive_level);
      return active ? ~passive_level : passive_level;
   endfunction

   function automatic logic [31:0] dtpwm_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

endpackage

// >>> rtl/dtpwm_timer.sv
// Purpose: period timer, edge aligned or center aligned
// Assumes: period is stable while a period runs (shadowed upstream)
// Notes:   start pulses once per period, on the cycle the count is zero
`timescale 1ns/100ps
module dtpwm_timer #(
   parameter int unsigned CW = 16
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          run,
   input  wire logic          center,
   input  wire logic [CW-1:0] period,
   output logic      [CW-1:0] cnt,
   output logic               down,
   output logic               start
);
   dtpwm_pkg::dtpwm_state_type state_q;
   logic [CW-1:0]              cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= dtpwm_pkg::DTPWM_IDLE;
         cnt_q   <= '0;
      end else begin
         case (state_q)
            dtpwm_pkg::DTPWM_IDLE: begin
               cnt_q <= '0;
               if (run) begin
                  state_q <= dtpwm_pkg::DTPWM_UP;
               end
            end
            dtpwm_pkg::DTPWM_UP: begin
               if (!run) begin
                  state_q <= dtpwm_pkg::DTPWM_IDLE;
                  cnt_q   <= '0;
               end else if (cnt_q >= period) begin
                  if (center) begin
                     state_q <= dtpwm_pkg::DTPWM_DOWN;
                     cnt_q   <= (cnt_q == '0) ? '0 : cnt_q - 1'b1;
                  end else begin
                     cnt_q <= '0;
                  end
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            dtpwm_pkg::DTPWM_DOWN: begin
               if (!run) begin
                  state_q <= dtpwm_pkg::DTPWM_IDLE;
                  cnt_q   <= '0;
               end else if (cnt_q <= CW'(1)) begin
                  state_q <= dtpwm_pkg::DTPWM_UP;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: begin
               state_q <= dtpwm_pkg::DTPWM_IDLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

   assign cnt   = cnt_q;
   assign down  = (state_q == dtpwm_pkg::DTPWM_DOWN);
   assign start = (state_q == dtpwm_pkg::DTPWM_UP) && (cnt_q == '0);

endmodule // dtpwm_timer

// >>> rtl/dtpwm_channel.sv
// Purpose: one channel: compare state, dead time, complementary pin pair
// Assumes: st is the compare state, high while count >= compare value
// Notes:   an edge inside a running dead time restarts it
`timescale 1ns/100ps
module dtpwm_channel #(
   parameter int unsigned DW = 10
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          run,
   input  wire logic          st,
   input  wire logic [DW-1:0] dead_time,
   input  wire logic [3:0]    cfg,
   output logic               prim_out,
   output logic               comp_out,
   output logic               match
);
   logic          st_q;
   logic [DW-1:0] dt_q;
   logic          prim_q;
   logic          comp_q;
   logic          done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= 1'b0;
      end else begin
         st_q <= run & st;
      end
   end

   assign match = run & st & ~st_q;

   // both pins stay off while the count runs, so neither switches on early
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_q <= '0;
      end else if (!run) begin
         dt_q <= '0;
      end else if ((run & st) != st_q) begin
         dt_q <= dead_time;
      end else if (dt_q != '0) begin
         dt_q <= dt_q - 1'b1;
      end
   end

   assign done = (dt_q == '0);

   // reset value 0 equals the passive level after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prim_q <= 1'b0;
         comp_q <= 1'b0;
      end else begin
         prim_q <= dtpwm_pkg::dtpwm_pin(run & done &
                   dtpwm_pkg::dtpwm_active(st_q, cfg[dtpwm_pkg::CFG_P_AFTER]),
                   cfg[dtpwm_pkg::CFG_P_LEVEL]);
         comp_q <= dtpwm_pkg::dtpwm_pin(run & done &
                   dtpwm_pkg::dtpwm_active(st_q, cfg[dtpwm_pkg::CFG_C_AFTER]),
                   cfg[dtpwm_pkg::CFG_C_LEVEL]);
      end
   end

   assign prim_out = prim_q;
   assign comp_out = comp_q;

endmodule // dtpwm_channel

// >>> rtl/dtpwm_top.sv
// Purpose: multi-channel dead-time pwm generator with an apb register file
// Assumes: apb with zero wait states; all inputs synchronous to pclk
// Notes:   compare and period values are shadowed and taken at period start
//
// Contract
// - timer restarts after reaching period match
// - four independent compare values, channels 0-3
// - compare match when count passes compare value
// - each channel drives complementary output pair
// - passive phase and level configurable per output
// - edge and center aligned counting modes
// - dead time delays switching on
// - dead time above compare holds one output
// - compare equal period still matches, below full
// - compare above period never matches, full on
// - full on via compare zero or above period
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module dtpwm_top #(
   parameter int unsigned NCH = dtpwm_pkg::NCH,
   parameter int unsigned CW  = dtpwm_pkg::CW,
   parameter int unsigned DW  = dtpwm_pkg::DW
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic [dtpwm_pkg::AW-1:0] paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   output logic      [NCH-1:0]          primary_pwm_out,
   output logic      [NCH-1:0]          complementary_pwm_out
);
   logic [2:0]          ctrl_q;
   logic [CW-1:0]       period_q;
   logic [CW-1:0]       period_act_q;
   logic [DW-1:0]       dt_q;
   logic [4*NCH-1:0]    outcfg_q;
   logic [CW-1:0]       cmp_q     [NCH];
   logic [CW-1:0]       cmp_act_q [NCH];
   logic [NCH-1:0]      match_q;
   logic [31:0]         pcount_q;
   logic [31:0]         prdata_q;

   logic                run;
   logic                center;
   logic                load;
   logic [CW-1:0]       cnt;
   logic                down;
   logic                start;
   logic [NCH-1:0]      st;
   logic [NCH-1:0]      match_ev;
   logic                wr;
   logic                rd_setup;
   logic                hit;
   logic                cmp_sel;
   logic [1:0]          cmp_idx;
   logic [31:0]         rdata;
   logic [31:0]         wnew;

   assign run    = ctrl_q[dtpwm_pkg::CTRL_RUN_BIT];
   assign center = ctrl_q[dtpwm_pkg::CTRL_CENTER_BIT];

   // ---------------------------------------------------------------- apb
   assign wr       = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign cmp_sel  = (paddr >= dtpwm_pkg::OFF_CMP0) && (paddr <= dtpwm_pkg::OFF_CMP_LAST)
                     && (paddr[1:0] == 2'h0);
   assign cmp_idx  = paddr[3:2];

   always_comb begin
      case (paddr)
         dtpwm_pkg::OFF_CTRL,
         dtpwm_pkg::OFF_PERIOD,
         dtpwm_pkg::OFF_DEADTIME,
         dtpwm_pkg::OFF_OUTCFG,
         dtpwm_pkg::OFF_STATUS,
         dtpwm_pkg::OFF_OUTSTAT,
         dtpwm_pkg::OFF_MATCH,
         dtpwm_pkg::OFF_PCOUNT: hit = 1'b1;
         default:               hit = cmp_sel;
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   always_comb begin
      rdata = 32'h0000_0000;
      case (paddr)
         dtpwm_pkg::OFF_CTRL:     rdata[1:0]     = ctrl_q[1:0];
         dtpwm_pkg::OFF_PERIOD:   rdata[CW-1:0]  = period_q;
         dtpwm_pkg::OFF_DEADTIME: rdata[DW-1:0]  = dt_q;
         dtpwm_pkg::OFF_OUTCFG:   rdata[4*NCH-1:0] = outcfg_q;
         dtpwm_pkg::OFF_STATUS: begin
            rdata[CW-1:0] = cnt;
            rdata[CW]     = down;
            rdata[CW+1]   = run;
         end
         dtpwm_pkg::OFF_OUTSTAT: begin
            rdata[NCH-1:0]       = primary_pwm_out;
            rdata[2*NCH-1:NCH]   = complementary_pwm_out;
            rdata[3*NCH-1:2*NCH] = st;
         end
         dtpwm_pkg::OFF_MATCH:    rdata[NCH-1:0] = match_q;
         dtpwm_pkg::OFF_PCOUNT:   rdata          = pcount_q;
         default: begin
            if (cmp_sel) begin
               rdata[CW-1:0] = cmp_q[cmp_idx];
            end
         end
      endcase
   end

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_q <= rdata;
      end
   end

   assign prdata = prdata_q;

   always_comb begin
      wnew = 32'h0000_0000;
      case (paddr)
         dtpwm_pkg::OFF_CTRL:     wnew[2:0]        = ctrl_q;
         dtpwm_pkg::OFF_PERIOD:   wnew[CW-1:0]     = period_q;
         dtpwm_pkg::OFF_DEADTIME: wnew[DW-1:0]     = dt_q;
         dtpwm_pkg::OFF_OUTCFG:   wnew[4*NCH-1:0]  = outcfg_q;
         default: begin
            if (cmp_sel) begin
               wnew[CW-1:0] = cmp_q[cmp_idx];
            end
         end
      endcase
      wnew = dtpwm_pkg::dtpwm_strb(wnew, pwdata, pstrb);
   end

   // ---------------------------------------------------------- registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= {1'b0, dtpwm_pkg::CTRL_RST};
      end else if (wr && paddr == dtpwm_pkg::OFF_CTRL) begin
         ctrl_q <= wnew[2:0];
      end else begin
         ctrl_q[dtpwm_pkg::CTRL_LOAD_BIT] <= 1'b0;
      end
   end

   assign load = ctrl_q[dtpwm_pkg::CTRL_LOAD_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_q <= CW'(dtpwm_pkg::PERIOD_RST);
      end else if (wr && paddr == dtpwm_pkg::OFF_PERIOD) begin
         period_q <= wnew[CW-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_q <= DW'(dtpwm_pkg::DT_RST);
      end else if (wr && paddr == dtpwm_pkg::OFF_DEADTIME) begin
         dt_q <= wnew[DW-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outcfg_q <= (4*NCH)'(dtpwm_pkg::OUTCFG_RST);
      end else if (wr && paddr == dtpwm_pkg::OFF_OUTCFG) begin
         outcfg_q <= wnew[4*NCH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            cmp_q[i] <= CW'(dtpwm_pkg::CMP_RST);
         end
      end else if (wr && cmp_sel) begin
         cmp_q[cmp_idx] <= wnew[CW-1:0];
      end
   end

   // shadow transfer at period start, while stopped or on a load write, so a period never sees a torn value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_act_q <= CW'(dtpwm_pkg::PERIOD_RST);
         for (int i = 0; i < NCH; i++) begin
            cmp_act_q[i] <= CW'(dtpwm_pkg::CMP_RST);
         end
      end else if (!run || start || load) begin
         period_act_q <= period_q;
         for (int i = 0; i < NCH; i++) begin
            cmp_act_q[i] <= cmp_q[i];
         end
      end
   end

   // sticky match flags, write one to clear; a new match wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_q <= '0;
      end else if (wr && paddr == dtpwm_pkg::OFF_MATCH) begin
         match_q <= (match_q & ~pwdata[NCH-1:0]) | match_ev;
      end else begin
         match_q <= match_q | match_ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcount_q <= 32'h0000_0000;
      end else if (wr && paddr == dtpwm_pkg::OFF_PCOUNT) begin
         pcount_q <= 32'h0000_0000;
      end else if (start) begin
         pcount_q <= pcount_q + 32'h0000_0001;
      end
   end

   // --------------------------------------------------------------- core
   dtpwm_timer #(
      .CW (CW)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run),
      .center  (center),
      .period  (period_act_q),
      .cnt     (cnt),
      .down    (down),
      .start   (start)
   );

   // compare above period is never reached; zero holds for the whole period
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         st[i] = run && (cnt >= cmp_act_q[i]);
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      dtpwm_channel #(
         .DW (DW)
      ) u_ch (
         .pclk      (pclk),
         .presetn   (presetn),
         .run       (run),
         .st        (st[g]),
         .dead_time (dt_q),
         .cfg       (outcfg_q[4*g +: 4]),
         .prim_out  (primary_pwm_out[g]),
         .comp_out  (complementary_pwm_out[g]),
         .match     (match_ev[g])
      );
   end

endmodule // dtpwm_top

// >>> test/dtpwm_top_properties.sv
// Purpose: concurrent checks on the pwm pin pairs and the apb answers
// Assumes: config registers are written with every byte strobe set
// Notes:   snoops apb writes to learn levels, dead time and run state
`timescale 1ns/100ps
module dtpwm_chk #(
   parameter int unsigned NCH = 4,
   parameter int unsigned CW  = 16,
   parameter int unsigned DW  = 10
) (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic [dtpwm_pkg::AW-1:0] paddr,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [31:0]              pwdata,
   input wire logic [3:0]               pstrb,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic [NCH-1:0]           primary_pwm_out,
   input wire logic [NCH-1:0]           complementary_pwm_out
);
   logic [15:0]    cfg_q;
   logic [DW-1:0]  dt_q;
   logic           run_q;
   logic [7:0]     quiet_q;
   logic [NCH-1:0] act_p;
   logic [NCH-1:0] act_c;
   logic [NCH-1:0] pas_p;
   logic [NCH-1:0] pas_c;
   logic           wr_acc;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr_acc = psel && penable && pwrite && pready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= '0;
         dt_q <= '0;
         run_q <= 1'b0;
      end else if (wr_acc) begin
         if (paddr == dtpwm_pkg::OFF_OUTCFG) cfg_q <= pwdata[15:0];
         if (paddr == dtpwm_pkg::OFF_DEADTIME) dt_q <= pwdata[DW-1:0];
         if (paddr == dtpwm_pkg::OFF_CTRL) run_q <= pwdata[0];
      end
   end
   // outputs lag config by two flops, so checks wait until config settles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet_q <= '0;
      else if (wr_acc && (paddr == dtpwm_pkg::OFF_CTRL || paddr == dtpwm_pkg::OFF_DEADTIME
               || paddr == dtpwm_pkg::OFF_OUTCFG)) quiet_q <= '0;
      else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
   end
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [15:0] gap_q;
      assign pas_p[i] = cfg_q[4*i+1];
      assign pas_c[i] = cfg_q[4*i+3];
      assign act_p[i] = primary_pwm_out[i] ^ pas_p[i];
      assign act_c[i] = complementary_pwm_out[i] ^ pas_c[i];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) gap_q <= '0;
         else if (act_p[i] || act_c[i]) gap_q <= '0;
         else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
      end
      prim_gap_a: assert property ($rose(act_p[i]) && quiet_q > 8'h03 |-> gap_q >= 16'(dt_q))
         else $error("primary switched on inside dead time");
      comp_gap_a: assert property ($rose(act_c[i]) && quiet_q > 8'h03 |-> gap_q >= 16'(dt_q))
         else $error("complementary switched on inside dead time");
   end
   sequence acc_s;
      psel && penable;
   endsequence
   sequence rd_unmap_s;
      psel && penable && !pwrite && paddr[1:0] == 2'h0 && paddr > dtpwm_pkg::OFF_CMP_LAST;
   endsequence
   rst_passive_a: assert property ($rose(presetn) |-> primary_pwm_out == '0 && complementary_pwm_out == '0)
      else $error("outputs not passive after reset");
   idle_passive_a: assert property (!run_q && quiet_q > 8'h03 |->
      primary_pwm_out == pas_p && complementary_pwm_out == pas_c) else $error("stopped outputs not passive");
   no_overlap_a: assert property (quiet_q > 8'h03 |-> (act_p & act_c) == '0)
      else $error("both outputs of a pair active");
   ready_ok_a: assert property (acc_s |-> pready)
      else $error("access phase without ready");
   err_set_a: assert property (acc_s ##0 paddr[1:0] == 2'h0 |-> pslverr == (paddr > dtpwm_pkg::OFF_CMP_LAST))
      else $error("error response wrong for address");
   err_idle_a: assert property (!(psel && penable) |-> !pslverr)
      else $error("error response outside access");
   err_rdata_a: assert property (rd_unmap_s |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
endmodule // dtpwm_chk
bind dtpwm_top dtpwm_chk #(.NCH(NCH), .CW(CW), .DW(DW)) chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .primary_pwm_out(primary_pwm_out),
   .complementary_pwm_out(complementary_pwm_out));

// >>> test/dtpwm_bridge_model.sv
// Purpose: bridge driver seen from the pwm pins, counts switch on-time
// Assumes: primary pin drives the high side, complementary the low side
// Notes:   counters clear on clr; shoot counts cycles with both switches on
`timescale 1ns/100ps
module dtpwm_bridge_model #(
   parameter int unsigned NCH = 4
) (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  inverted,
   input wire logic                  clr,
   input wire logic [NCH-1:0]        hs_in,
   input wire logic [NCH-1:0]        ls_in,
   output logic     [NCH-1:0]        hs_on,
   output logic     [NCH-1:0]        ls_on,
   output logic     [NCH-1:0][15:0]  hs_cnt,
   output logic     [NCH-1:0][15:0]  ls_cnt,
   output logic     [15:0]           shoot_cnt
);
   // an inverting driver only suits pins whose passive level is high
   assign hs_on = inverted ? ~hs_in : hs_in;
   assign ls_on = inverted ? ~ls_in : ls_in;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_cnt <= '0;
         ls_cnt <= '0;
         shoot_cnt <= '0;
      end else if (clr) begin
         hs_cnt <= '0;
         ls_cnt <= '0;
         shoot_cnt <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            hs_cnt[i] <= hs_cnt[i] + 16'(hs_on[i]);
            ls_cnt[i] <= ls_cnt[i] + 16'(ls_on[i]);
         end
         shoot_cnt <= shoot_cnt + 16'(|(hs_on & ls_on));
      end
   end
endmodule // dtpwm_bridge_model

// >>> test/dtpwm_top_tb.sv
// Purpose: self-checking bench for the dead-time pwm block
// Assumes: zero-wait apb slave, but the master still waits for ready
// Notes:   duty is measured over ten whole periods by the bridge model
`timescale 1ns/100ps
module dtpwm_top_tb;
   logic             pclk;
   logic             presetn;
   logic [7:0]       paddr;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [31:0]      pwdata;
   logic [3:0]       pstrb;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic [3:0]       prim;
   logic [3:0]       comp;
   logic             inv;
   logic             clr;
   logic [3:0][15:0] hs_cnt;
   logic [3:0][15:0] ls_cnt;
   logic [15:0]      shoot_cnt;
   logic [63:0]      exp_q[$];
   logic [31:0]      mirror[12];
   int               num_errors;
   int               n_tests;
   int               cyc;
   dtpwm_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .primary_pwm_out(prim), .complementary_pwm_out(comp));
   dtpwm_bridge_model #(.NCH(4)) drv_u (.pclk(pclk), .presetn(presetn), .inverted(inv), .clr(clr),
      .hs_in(prim), .ls_in(comp), .hs_on(), .ls_on(), .hs_cnt(hs_cnt), .ls_cnt(ls_cnt), .shoot_cnt(shoot_cnt));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      exp_q.push_back({m, e});
      apb(1'b0, a, 32'h0, 4'h0);
   endtask
   // on-cycles per period of one switch; a full-on side never sees dead time
   function automatic int unsigned on_cnt(input bit ctr, input int unsigned p, cm, dt, input bit hs);
      int unsigned len;
      int unsigned hi;
      int unsigned a;
      len = ctr ? 2 * p : p + 1;
      hi = (cm > p) ? 0 : (cm == 0) ? len : ctr ? 2 * (p - cm) + 1 : p + 1 - cm;
      a = hs ? hi : len - hi;
      if (a == 0 || a == len) return a;
      return (a > dt) ? a - dt : 0;
   endfunction
   task automatic run_case(input bit ctr, input int unsigned p, dt, input logic [15:0] cfg, input bit iv,
                           input int unsigned c[4]);
      int unsigned len;
      logic [31:0] mexp;
      logic [31:0] mnone;
      len = ctr ? 2 * p : p + 1;
      mexp = '0;
      mnone = '0;
      wr(dtpwm_pkg::OFF_CTRL, 32'h0);
      wr(dtpwm_pkg::OFF_MATCH, 32'hf);
      wr(dtpwm_pkg::OFF_PERIOD, 32'(p));
      wr(dtpwm_pkg::OFF_DEADTIME, 32'(dt));
      wr(dtpwm_pkg::OFF_OUTCFG, {16'h0, cfg});
      for (int i = 0; i < 4; i++) begin
         wr(8'(dtpwm_pkg::OFF_CMP0 + 4 * i), 32'(c[i]));
         mexp[i] = c[i] <= p;
         mnone[i] = c[i] == 0 || c[i] > p;
      end
      inv <= iv;
      wr(dtpwm_pkg::OFF_CTRL, {30'h0, ctr, 1'b1});
      repeat (4 * len) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (10 * len) @(posedge pclk);
      @(negedge pclk);
      for (int i = 0; i < 4; i++) begin
         check({16'h0, hs_cnt[i]}, 32'(10 * on_cnt(ctr, p, c[i], dt, 1'b1)));
         check({16'h0, ls_cnt[i]}, 32'(10 * on_cnt(ctr, p, c[i], dt, 1'b0)));
      end
      check({16'h0, shoot_cnt}, 32'h0);
      rd(dtpwm_pkg::OFF_STATUS, 32'h00020000, 32'h00020000);
      rd(dtpwm_pkg::OFF_MATCH, mexp, 32'hf);
      wr(dtpwm_pkg::OFF_MATCH, 32'hf);
      rd(dtpwm_pkg::OFF_MATCH, 32'h0, mnone);
      $display("test pwm case center=%0d done, mismatches %0d", ctr, num_errors);
   endtask
   // the monitor takes the oldest expectation whenever read data is handed over
   always @(posedge pclk) begin : mon_b
      logic [63:0] e;
      if (psel && penable && !pwrite && pready) begin
         e = exp_q.pop_front();
         check(prdata & e[63:32], e[31:0] & e[63:32]);
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      int unsigned sel[6];
      int unsigned idx;
      logic [31:0] d;
      logic [3:0] s;
      sel = '{1, 2, 8, 9, 10, 11};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      inv = 1'b0;
      clr = 1'b0;
      num_errors = 0;
      n_tests = 0;
      cyc = 0;
      void'($urandom(32'heef66179));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         mirror[i] = (i == 1) ? 32'hff : 32'h0;
         rd(8'(4 * i), mirror[i]);
      end
      rd(8'h30, 32'h0);
      apb(1'b1, 8'h30, 32'hffffffff, 4'hf);
      apb(1'b1, dtpwm_pkg::OFF_STATUS, 32'hffffffff, 4'hf);
      rd(dtpwm_pkg::OFF_STATUS, 32'h0);
      wr(dtpwm_pkg::OFF_CTRL, 32'h4);
      rd(dtpwm_pkg::OFF_CTRL, 32'h0);
      $display("test reset values done, mismatches %0d", num_errors);
      for (int k = 0; k < 10; k++) begin
         idx = sel[$urandom_range(5, 0)];
         d = $urandom;
         s = 4'($urandom);
         for (int b = 0; b < 4; b++) if (s[b]) mirror[idx][8*b +: 8] = d[8*b +: 8];
         mirror[idx] &= (idx == 2) ? 32'h3ff : 32'hffff;
         apb(1'b1, 8'(4 * idx), d, s);
         rd(8'(4 * idx), mirror[idx]);
      end
      $display("test register access done, mismatches %0d", num_errors);
      run_case(1'b0, 9, 2, 16'h4444, 1'b0, '{4, 0, 9, 10});
      run_case(1'b1, 5, 1, 16'heeee, 1'b1, '{$urandom_range(6, 0), 0, 5, $urandom_range(6, 1)});
      run_case(1'b0, 9, 5, 16'h4444, 1'b0, '{3, $urandom_range(10, 0), 7, 10});
      repeat (4) @(posedge pclk);
      check(32'(exp_q.size()), 32'h0);
      conclude();
   end
endmodule // dtpwm_top_tb
